// ### pmic_status_mask_enable_regs_tb_top.sv
// Purpose: self-checking bench for the supply status, mask and enable bank
// Assumes: host model drives the serial port; open-drain lines pulled up
// Notes: identification value is arbitrary
`timescale 1ns/1ps
module pmic_status_mask_enable_regs_tb_top;
  localparam [7:0] ID = 8'hA7;  // Arbitrary identification value
  reg        clk_sys = 1'b0;
  reg        srst = 1'b1;
  reg        lkout = 1'b0;
  reg        pf = 1'b0;
  reg        lb = 1'b0;
  reg        dvs = 1'b0;
  reg  [4:0] rail = 5'h00;
  reg  [3:0] pins = 4'hF;  // Core, system, memory, linear
  wire       scl, sda_drv, sda_oe_n_q, sda_out_q, int_oe_n_q, int_out_q;
  wire [4:0] supply_on_q;
  wire       sda = sda_drv & (sda_oe_n_q | sda_out_q);
  wire       int_n = int_oe_n_q | int_out_q;
  int        error_cnt = 0;
  int        tests_run = 0;
  logic [7:0] e;
  logic [7:0] b0;
  logic [7:0] b1;
  logic      nak;
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  pmsr_top #(.CHIP_ID(ID)) dut (.clk_sys(clk_sys), .srst(srst), .undervoltage_lockout(lkout),
    .scl_in(scl), .sda_in(sda), .sda_out_q(sda_out_q), .sda_oe_n_q(sda_oe_n_q),
    .int_out_q(int_out_q), .int_oe_n_q(int_oe_n_q), .power_fail_sense(pf),
    .low_battery_sense(lb), .rail_low(rail), .dynamic_voltage_scaling(dvs),
    .core_buck_enable_pin(pins[3]), .system_buck_enable_pin(pins[2]),
    .memory_buck_enable_pin(pins[1]), .linear_regs_enable_pin(pins[0]),
    .supply_on_q(supply_on_q));
  pmsr_host h (.clk_sys(clk_sys), .sda_line(sda), .scl(scl), .sda_drv(sda_drv));
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] o, input logic [7:0] x);
    logic [7:0] q;
    logic [7:0] w;
    h.rd(o, 1'b0, q, w);
    chk(q, x);
  endtask
  task automatic wrc(input logic [7:0] o, input logic [7:0] d);
    logic n;
    h.wr(8'h90, o, d, n);
    chk({7'h00, n}, 8'h00);
  endtask
  task automatic ck_int(input logic v);
    chk({7'h00, int_n}, {7'h00, v});
  endtask
  task automatic results;
    $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // About five times the expected run
  initial begin
    #1_000_000;
    error_cnt++;
    $display("Error %0t: watchdog expired", $time);
    results;
  end
  initial begin
    step(6);
    srst = 1'b0;
    step(4);
    rdc(8'h00, ID);
    rdc(8'h02, 8'hC0);
    rdc(8'h03, 8'hFF);
    rdc(8'h07, 8'hFF);
    rdc(8'h01, 8'h00);
    ck_int(1'b1);
    wrc(8'h00, 8'h00);
    rdc(8'h00, ID);
    wrc(8'h01, 8'hFF);
    rdc(8'h01, 8'h00);
    wrc(8'h02, 8'hFF);
    rdc(8'h02, 8'hFE);
    $display("done: reset values and read-only places");
    pf = 1'b1;
    lb = 1'b1;
    step(6);
    rdc(8'h01, 8'hC0);
    ck_int(1'b1);
    wrc(8'h02, 8'h00);
    ck_int(1'b0);
    rdc(8'h01, 8'hC0);
    ck_int(1'b1);
    pf = 1'b0;
    lb = 1'b0;
    step(6);
    rail = 5'h1F;
    step(6);
    ck_int(1'b0);
    rdc(8'h01, 8'h3E);
    wrc(8'h03, 8'hF7);
    chk({3'h0, supply_on_q}, 8'h1B);
    rdc(8'h01, 8'h36);
    wrc(8'h03, 8'hFF);
    dvs = 1'b1;
    step(6);
    rdc(8'h01, 8'h36);
    dvs = 1'b0;
    rail = 5'h00;
    $display("done: status and interrupt");
    wrc(8'h03, 8'h00);
    rdc(8'h03, 8'hC1);
    chk({3'h0, supply_on_q}, 8'h00);
    ck_int(1'b0);
    e = 8'hC1;
    for (int i = 0; i < 4; i++) begin
      pins[i] = 1'b0;
      step(6);
      pins[i] = 1'b1;
      step(6);
      e = e | ((i == 0) ? 8'h06 : (8'h04 << i));
      rdc(8'h03, e);
    end
    chk({3'h0, supply_on_q}, 8'h1F);
    $display("done: enable pins");
    wrc(8'h02, 8'h12);
    wrc(8'h03, 8'hE1);
    lkout = 1'b1;
    step(6);
    lkout = 1'b0;
    step(6);
    rdc(8'h02, 8'hC0);
    rdc(8'h03, 8'hFF);
    h.rd(8'h02, 1'b1, b0, b1);
    chk(b0, 8'hC0);
    chk(b1, 8'hFF);
    h.wr(8'h92, 8'h02, 8'h00, nak);
    chk({7'h00, nak}, 8'h01);
    rdc(8'h02, 8'hC0);
    $display("done: lockout and foreign address");
    results;
  end
endmodule // pmic_status_mask_enable_regs_tb_top

// ### pmsr_chk_asserts.sv
// Purpose: port checks for the supply status, mask and enable bank
// Assumes: pins reach the registers through a two-flop synchroniser
// Notes: bound to pmsr_top
`timescale 1ns/1ps
module pmsr_chk (
  // Clock and reset
  input wire       clk_sys,
  input wire       srst,
  // Serial and interrupt pins
  input wire       scl_in,
  input wire       sda_oe_n_q,
  input wire       int_oe_n_q,
  // Enable pins and supply switches
  input wire       core_buck_enable_pin,
  input wire       system_buck_enable_pin,
  input wire       memory_buck_enable_pin,
  input wire       linear_regs_enable_pin,
  input wire [4:0] supply_on_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Pin held low, then back high long enough to pass the synchroniser
  sequence s_core_cycle;
    !core_buck_enable_pin [*4] ##1 core_buck_enable_pin [*6];
  endsequence
  sequence s_lin_cycle;
    !linear_regs_enable_pin [*4] ##1 linear_regs_enable_pin [*6];
  endsequence
  property p_core_off; !core_buck_enable_pin [*5] |-> !supply_on_q[4]; endproperty
  a_core_off: assert property (p_core_off) else $error("core on, pin low");
  property p_sys_off; !system_buck_enable_pin [*5] |-> !supply_on_q[3]; endproperty
  a_sys_off: assert property (p_sys_off) else $error("system on, pin low");
  property p_mem_off; !memory_buck_enable_pin [*5] |-> !supply_on_q[2]; endproperty
  a_mem_off: assert property (p_mem_off) else $error("memory on, pin low");
  property p_lin_off; !linear_regs_enable_pin [*5] |-> supply_on_q[1:0] == 2'h0; endproperty
  a_lin_off: assert property (p_lin_off) else $error("linear on, pin low");
  property p_core_back; s_core_cycle |-> supply_on_q[4]; endproperty
  a_core_back: assert property (p_core_back) else $error("core not back on");
  property p_lin_back; s_lin_cycle |-> &supply_on_q[1:0]; endproperty
  a_lin_back: assert property (p_lin_back) else $error("linear not back on");
  property p_none_int; (supply_on_q == 5'h00) [*4] |-> !int_oe_n_q; endproperty
  a_none_int: assert property (p_none_int) else $error("interrupt released, none on");
  property p_sda_edge; $changed(sda_oe_n_q) |-> !$past(scl_in, 2); endproperty
  a_sda_edge: assert property (p_sda_edge) else $error("data changed, clock high");
endmodule // pmsr_chk

bind pmsr_top pmsr_chk u_chk (.clk_sys, .srst, .scl_in, .sda_oe_n_q, .int_oe_n_q,
  .core_buck_enable_pin, .system_buck_enable_pin, .memory_buck_enable_pin,
  .linear_regs_enable_pin, .supply_on_q);

// ### pmsr_host.sv
// Purpose: host master model for the two-wire register port
// Assumes: 160 ns serial clock, eight clk_sys per bit
// Notes: lines idle high through pull-ups; serial clock stands still between frames
`timescale 1ns/1ps
module pmsr_host (
  // Clock
  input wire clk_sys,
  // Serial lines
  input wire sda_line,
  output reg scl,
  output reg sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // One serial clock; a differs from z only for start and stop
  task automatic phase(input logic a, input logic z, input logic f, output logic r);
    hw(2);
    sda_drv = a;
    hw(2);
    scl = 1'b1;
    hw(3);
    r = sda_line;
    hw(1);
    sda_drv = z;
    if (z != a) hw(4);
    scl = !f;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic l, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) phase(d[i], d[i], 1'b1, q[i]);
    phase(l, l, 1'b1, k);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] o, input logic [7:0] d,
                    output logic n);
    logic [7:0] q;
    logic       k;
    phase(1'b1, 1'b0, 1'b1, k);
    xbyte(a, 1'b1, q, n);
    xbyte(o, 1'b1, q, k);
    xbyte(d, 1'b1, q, k);
    phase(1'b0, 1'b1, 1'b0, k);
  endtask
  task automatic rd(input logic [7:0] o, input logic two, output logic [7:0] v,
                    output logic [7:0] w);
    logic [7:0] q;
    logic       k;
    phase(1'b1, 1'b0, 1'b1, k);
    xbyte(8'h90, 1'b1, q, k);
    xbyte(o, 1'b1, q, k);
    phase(1'b1, 1'b0, 1'b1, k);
    xbyte(8'h91, 1'b1, q, k);
    xbyte(8'hFF, !two, v, k);
    if (two) xbyte(8'hFF, 1'b1, w, k);
    else w = 8'hFF;
    phase(1'b0, 1'b1, 1'b0, k);
  endtask
endmodule // pmsr_host

// ### pmsr_regs.vh
// Purpose: constants for the supply status, mask and enable register bank
// Assumes: included by pmsr_top.v only
// Notes: offsets are register indices on the two-wire serial port
`ifndef PMSR_REGS_VH
`define PMSR_REGS_VH

`define PMSR_DEV_ADDR     7'h48
`define PMSR_OFS_ID       8'h00
`define PMSR_OFS_STATUS   8'h01
`define PMSR_OFS_MASK     8'h02
`define PMSR_OFS_ENABLE   8'h03
`define PMSR_MASK_RST     8'hC0
`define PMSR_ENABLE_RST   8'hFF
`define PMSR_UNMAPPED     8'hFF
`define PMSR_BIT0_CLR     8'hFE
`define PMSR_BIT_PF       7
`define PMSR_BIT_LB       6
`define PMSR_BIT_MEM      3
`define PMSR_SYNC_STAGES  2

`endif

// ### pmsr_sync.v
// Purpose: two-flop synchroniser for a bundle of asynchronous levels
// Assumes: each bit is an independent level
// Notes: only the second stage is visible outside
`timescale 1ns/1ps
module pmsr_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clk_sys,
  input  wire         srst,
  // Levels
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_q
);

  reg [W-1:0] meta_q;

  always @(posedge clk_sys) begin
    if (srst) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

endmodule // pmsr_sync

// ### pmsr_top.v
// Purpose: status, mask and supply enable registers behind a two-wire serial slave
// Assumes: serial clock far slower than clk_sys; all pins asynchronous
// Notes: open-drain pins are driven low when their _oe_n is low
`timescale 1ns/1ps
`include "pmsr_regs.vh"
module pmsr_top #(
  parameter [7:0] CHIP_ID = 8'h5A  // Arbitrary identification value
) (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       srst,
  input  wire       undervoltage_lockout,
  // Serial bus
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out_q,
  output reg        sda_oe_n_q,
  // Interrupt pin, open drain
  output reg        int_out_q,
  output reg        int_oe_n_q,
  // Comparators, 1 = below threshold; scaling flag, 1 = active
  input  wire       power_fail_sense,
  input  wire       low_battery_sense,
  input  wire [4:0] rail_low,         // Core, system, memory buck, linear two, linear one
  input  wire       dynamic_voltage_scaling,
  // Enable pins
  input  wire       core_buck_enable_pin,
  input  wire       system_buck_enable_pin,
  input  wire       memory_buck_enable_pin,
  input  wire       linear_regs_enable_pin,
  // Supply switches
  output reg  [4:0] supply_on_q
);

  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_ADDR = 9'h002;
  localparam [8:0] S_ACKA = 9'h004;
  localparam [8:0] S_REG  = 9'h008;
  localparam [8:0] S_ACKR = 9'h010;
  localparam [8:0] S_WDAT = 9'h020;
  localparam [8:0] S_ACKW = 9'h040;
  localparam [8:0] S_RDAT = 9'h080;
  localparam [8:0] S_RACK = 9'h100;

  wire [14:0] s;
  pmsr_sync #(.W(15)) u_sync (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .async_in ({undervoltage_lockout, scl_in, sda_in, power_fail_sense, low_battery_sense,
                rail_low, dynamic_voltage_scaling, core_buck_enable_pin,
                system_buck_enable_pin, memory_buck_enable_pin, linear_regs_enable_pin}),
    .sync_q   (s)
  );

  wire       lkout  = s[14];
  wire       scl    = s[13];
  wire       sda    = s[12];
  wire       pf     = s[11];
  wire       lb     = s[10];
  wire [4:0] rlow   = s[9:5];
  wire       dvs    = s[4];
  wire [4:0] en_pin = {s[3], s[2], s[1], s[0], s[0]};

  reg        scl_q;
  reg        sda_q;
  reg  [8:0] state_q;
  reg  [3:0] cnt_q;
  reg  [7:0] sr_q;
  reg  [7:0] ptr_q;
  reg        rw_q;
  reg        mack_q;
  reg  [7:0] mask_q;
  reg  [4:0] ena_q;
  reg        rel_q;

  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire start_c  = scl & scl_q & sda_q & ~sda;
  wire stop_c   = scl & scl_q & ~sda_q & sda;
  wire rst_all  = srst | lkout;

  wire [4:0] on_now = ena_q & en_pin;
  reg  [4:0] rail_bits;
  always @* begin
    rail_bits = rlow & on_now;
    if (dvs) begin
      rail_bits[`PMSR_BIT_MEM-1] = 1'b0;
    end
  end
  // Live view, never stored
  wire [7:0] status = {pf, lb, rail_bits, 1'b0};

  wire fault     = |(status & ~mask_q);
  wire none_on   = ~|on_now;
  // After a master acknowledge the next byte comes from the following register
  wire [7:0] rd_ptr   = (state_q == S_RACK) ? ptr_q + 8'h01 : ptr_q;
  wire       ptr_stat = (rd_ptr == `PMSR_OFS_STATUS);

  reg [7:0] rd_data;
  always @* begin
    case (rd_ptr)
      `PMSR_OFS_ID:     rd_data = CHIP_ID;
      `PMSR_OFS_STATUS: rd_data = status;
      `PMSR_OFS_MASK:   rd_data = mask_q;
      `PMSR_OFS_ENABLE: rd_data = {2'b11, ena_q, 1'b1};
      default:          rd_data = `PMSR_UNMAPPED;
    endcase
  end

  // Serial slave
  always @(posedge clk_sys) begin
    if (srst) begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      state_q    <= S_IDLE;
      cnt_q      <= 4'h0;
      sr_q       <= 8'h00;
      ptr_q      <= 8'h00;
      rw_q       <= 1'b0;
      mack_q     <= 1'b0;
      sda_oe_n_q <= 1'b1;
      sda_out_q  <= 1'b0;
    end else begin
      sda_out_q <= 1'b0;  // Open drain: only the enable moves
      scl_q <= scl;
      sda_q <= sda;
      if (stop_c) begin
        state_q    <= S_IDLE;
        sda_oe_n_q <= 1'b1;
      end else if (start_c) begin
        state_q    <= S_ADDR;
        cnt_q      <= 4'h0;
        sda_oe_n_q <= 1'b1;
      end else if (scl_rise) begin
        if (state_q == S_ADDR || state_q == S_REG || state_q == S_WDAT) begin
          sr_q  <= {sr_q[6:0], sda};
          cnt_q <= cnt_q + 4'h1;
        end else if (state_q == S_RDAT) begin
          cnt_q <= cnt_q + 4'h1;
        end else if (state_q == S_RACK) begin
          mack_q <= ~sda;
        end
      end else if (scl_fall) begin
        case (state_q)
          S_ADDR: begin
            if (cnt_q == 4'h8) begin
              cnt_q <= 4'h0;
              if (sr_q[7:1] == `PMSR_DEV_ADDR) begin
                rw_q       <= sr_q[0];
                sda_oe_n_q <= 1'b0;
                state_q    <= S_ACKA;
              end else begin
                state_q <= S_IDLE;
              end
            end
          end
          S_ACKA: begin
            cnt_q <= 4'h0;
            if (rw_q) begin
              sr_q       <= rd_data;
              sda_oe_n_q <= rd_data[7];
              state_q    <= S_RDAT;
            end else begin
              sda_oe_n_q <= 1'b1;
              state_q    <= S_REG;
            end
          end
          S_REG: begin
            if (cnt_q == 4'h8) begin
              ptr_q      <= sr_q;
              sda_oe_n_q <= 1'b0;
              state_q    <= S_ACKR;
            end
          end
          S_WDAT: begin
            if (cnt_q == 4'h8) begin
              sda_oe_n_q <= 1'b0;
              state_q    <= S_ACKW;
            end
          end
          S_ACKR, S_ACKW: begin
            if (state_q == S_ACKW) begin
              ptr_q <= ptr_q + 8'h01;
            end
            cnt_q      <= 4'h0;
            sda_oe_n_q <= 1'b1;
            state_q    <= S_WDAT;
          end
          S_RDAT: begin
            if (cnt_q == 4'h8) begin
              sda_oe_n_q <= 1'b1;
              state_q    <= S_RACK;
            end else begin
              sr_q       <= {sr_q[6:0], 1'b1};
              sda_oe_n_q <= sr_q[6];
            end
          end
          S_RACK: begin
            cnt_q <= 4'h0;
            if (mack_q) begin
              ptr_q      <= ptr_q + 8'h01;
              sr_q       <= rd_data;
              sda_oe_n_q <= rd_data[7];
              state_q    <= S_RDAT;
            end else begin
              state_q <= S_IDLE;  // Master ended the read; leave the line high
            end
          end
          S_IDLE: begin
            sda_oe_n_q <= 1'b1;
          end
          default: begin
            state_q    <= S_IDLE;
            sda_oe_n_q <= 1'b1;
          end
        endcase
      end
    end
  end

  // Byte write strobe: end of the eighth write data bit, as the acknowledge starts
  wire wr_stb = scl_fall & ~stop_c & ~start_c & (state_q == S_WDAT) & (cnt_q == 4'h8);
  // Status byte loaded for shifting out
  wire rd_stat = scl_fall & ~stop_c & ~start_c & rw_q & ptr_stat &
                 ((state_q == S_ACKA) | ((state_q == S_RACK) & mack_q));

  wire [7:0] ena_rst = `PMSR_ENABLE_RST;

  // Registers
  always @(posedge clk_sys) begin
    if (rst_all) begin
      mask_q <= `PMSR_MASK_RST;
      ena_q  <= ena_rst[5:1];
    end else begin
      if (wr_stb && ptr_q == `PMSR_OFS_MASK) begin
        mask_q <= sr_q & `PMSR_BIT0_CLR;
      end
      if (wr_stb && ptr_q == `PMSR_OFS_ENABLE) begin
        ena_q <= sr_q[5:1] | ~en_pin;
      end else begin
        ena_q <= ena_q | ~en_pin;
      end
    end
  end

  // Interrupt pin and supply switches
  always @(posedge clk_sys) begin
    if (rst_all) begin
      rel_q       <= 1'b0;
      int_out_q   <= 1'b0;
      int_oe_n_q  <= 1'b0;
      supply_on_q <= 5'h00;
    end else begin
      if (rd_stat && fault) begin
        rel_q <= 1'b1;
      end else if (!fault) begin
        rel_q <= 1'b0;
      end
      int_out_q   <= 1'b0;
      int_oe_n_q  <= ~(none_on | (fault & ~rel_q));
      supply_on_q <= on_now;
    end
  end

endmodule // pmsr_top
